// *** updown_ref_pkg.sv ***
// Package for the up/down frequency reference block: register offset,
// selector codes, timing constants and the carrier structs.
// Assumes a 100 MHz system clock and 16-bit frequency words in 0.01 Hz.
package updown_ref_pkg;

    // Register offset and reset value of the memory selector.
    localparam logic [15:0] FREQ_MEM_SEL_OFFSET = 16'h0164;
    localparam logic [15:0] FREQ_MEM_SEL_RESET  = 16'h0000;

    // Selector codes.
    localparam logic [15:0] INPUT7_UPDOWN_CODE  = 16'h0022;
    localparam logic [15:0] MEM_SEL_RETAIN      = 16'h0001;
    localparam logic [15:0] MEM_SEL_OFF         = 16'h0000;
    localparam logic [15:0] INIT_CODE_A         = 16'h0008;
    localparam logic [15:0] INIT_CODE_B         = 16'h0009;

    // Hold time before a frequency is stored, and the ramp step period.
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned HOLD_TIME_S    = 5;
    localparam longint unsigned HOLD_CYCLES =
        longint'(HOLD_TIME_S) * longint'(CLK_HZ);
    localparam int unsigned RAMP_TIME_US   = 10;
    localparam int unsigned RAMP_CYCLES    =
        RAMP_TIME_US * (CLK_HZ / 1_000_000);
    localparam logic [15:0] RAMP_STEP      = 16'h0001;

    // Frequency limit settings applied by the clamp.
    typedef struct packed {
        logic [15:0] max_frequency_setting;
        logic [15:0] ref_upper_limit_setting;
        logic [15:0] min_output_freq_setting;
        logic [15:0] ref_lower_limit_setting;
    } limit_settings_t;

    // Terminal and command inputs.
    typedef struct packed {
        logic input6_terminal;
        logic input7_terminal;
        logic inching;
        logic run_fwd;
        logic run_rev;
        logic remote;
        logic multistep_sel;
    } terminal_in_t;

endpackage

// *** updown_limit_clamp.sv ***
// Limit clamp: forms upper and lower limits from the settings and clamps
// a requested frequency between them.
// Assumes unsigned frequency words in the same unit for every setting.
`timescale 1ns/1ps

module updown_limit_clamp
(
    input  wire updown_ref_pkg::limit_settings_t i_lim,
    input  wire logic [15:0]                    i_freq,
    output logic [15:0]                         o_upper,
    output logic [15:0]                         o_lower,
    output logic [15:0]                         o_clamped
);

    // Returns the smaller of two words.
    function automatic logic [15:0] min16(input logic [15:0] a,
                                          input logic [15:0] b);
        begin
            min16 = (a < b) ? a : b;
        end
    endfunction

    // Limits are the smaller of each pair of settings.
    assign o_upper = min16(i_lim.max_frequency_setting,
                           i_lim.ref_upper_limit_setting);
    assign o_lower = min16(i_lim.min_output_freq_setting,
                           i_lim.ref_lower_limit_setting);

    // Clamp the request between the limits.
    always_comb
    begin
        if (i_freq > o_upper)
            o_clamped = o_upper;
        else if (i_freq < o_lower)
            o_clamped = o_lower;
        else
            o_clamped = i_freq;
    end

endmodule

// *** updown_frequency_reference.sv ***
// Up/down frequency reference: ramps, holds and clamps the reference from
// two terminals and keeps a held value in retained storage.
// Assumes synchronous inputs, one clock and a retained store outside.
`timescale 1ns/1ps

module updown_frequency_reference
(
    input  wire logic                            i_sys_clk,
    input  wire logic                            i_arst_n,
    input  wire updown_ref_pkg::terminal_in_t    i_term,
    input  wire updown_ref_pkg::limit_settings_t i_lim,
    input  wire logic [15:0]                     i_input7_function_select,
    input  wire logic [15:0]                     i_param_initialize_select,
    input  wire logic [15:0]                     i_inching_freq,
    input  wire logic [15:0]                     i_multistep_freq,
    input  wire logic [15:0]                     i_retained_freq,
    input  wire logic                            i_retained_valid,
    input  wire logic                            i_reg_wr,
    input  wire logic                            i_reg_rd,
    input  wire logic [15:0]                     i_reg_addr,
    input  wire logic [15:0]                     i_reg_wdata,
    output logic [15:0]                          o_reg_rdata,
    output logic [15:0]                          o_freq_ref,
    output logic                                 o_updown_active,
    output logic                                 o_store_wr,
    output logic [15:0]                          o_store_data,
    output logic                                 o_store_erase
);

    ////////////////////////////////////////////////////////////////////////
    // Decode of terminals and mode.

    typedef enum logic [1:0]
    {
        DIR_HOLD = 2'b00,
        DIR_UP   = 2'b01,
        DIR_DOWN = 2'b10
    } dir_t;

    logic        mode_updown;
    dir_t        dir;
    logic        run_cmd;
    logic        run_prev_r;
    logic        run_rise;
    logic [15:0] mem_sel_r;
    logic        init_req;
    logic        mem_wr_hit;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [15:0] freq_r;
    logic [15:0] freq_nxt;
    logic [15:0] clamped;
    logic [15:0] req_freq;
    logic [31:0] ramp_cnt_r;
    logic [39:0] hold_cnt_r;
    logic        stored_r;
    logic        resume_r;
    logic [15:0] resume_freq_r;

    // Up/down mode exists only with the input-seven code.
    assign mode_updown = (i_input7_function_select ==
                          updown_ref_pkg::INPUT7_UPDOWN_CODE);

    // Only one active input gives a direction; equal inputs hold.
    always_comb
    begin
        case ({i_term.input6_terminal, i_term.input7_terminal})
            2'b10:   dir = DIR_UP;
            2'b01:   dir = DIR_DOWN;
            default: dir = DIR_HOLD;
        endcase
    end

    assign run_cmd  = i_term.run_fwd | i_term.run_rev;
    assign run_rise = run_cmd & ~run_prev_r;
    assign init_req = (i_param_initialize_select ==
                       updown_ref_pkg::INIT_CODE_A) ||
                      (i_param_initialize_select ==
                       updown_ref_pkg::INIT_CODE_B);
    assign mem_wr_hit = i_reg_wr &&
                        (i_reg_addr == updown_ref_pkg::FREQ_MEM_SEL_OFFSET);

    ////////////////////////////////////////////////////////////////////////
    // Limits and clamp.

    updown_limit_clamp u_clamp
    (
        .i_lim     (i_lim),
        .i_freq    (req_freq),
        .o_upper   (upper),
        .o_lower   (lower),
        .o_clamped (clamped)
    );

    ////////////////////////////////////////////////////////////////////////
    // Memory selector register.

    // Software writes the memory selector; it reads back unchanged.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            mem_sel_r <= updown_ref_pkg::FREQ_MEM_SEL_RESET;
        else if (mem_wr_hit)
            mem_sel_r <= i_reg_wdata;
    end

    // Read data returns the selector, or zero elsewhere.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_reg_rdata <= 16'h0000;
        else if (i_reg_rd &&
                 i_reg_addr == updown_ref_pkg::FREQ_MEM_SEL_OFFSET)
            o_reg_rdata <= mem_sel_r;
        else
            o_reg_rdata <= 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Resume value captured from the retained store.

    // A valid retained value is taken once while retention is selected.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            resume_r      <= 1'b0;
            resume_freq_r <= 16'h0000;
        end
        else if (init_req || (mem_sel_r == updown_ref_pkg::MEM_SEL_OFF))
        begin
            resume_r      <= 1'b0;
            resume_freq_r <= 16'h0000;
        end
        else if (o_store_wr)
        begin
            resume_r      <= 1'b1;
            resume_freq_r <= o_store_data;
        end
        else if (!resume_r && i_retained_valid &&
                 mem_sel_r == updown_ref_pkg::MEM_SEL_RETAIN)
        begin
            resume_r      <= 1'b1;
            resume_freq_r <= i_retained_freq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference update.

    // Choose the request before clamping.
    always_comb
    begin
        req_freq = freq_r;
        if (!mode_updown)
            req_freq = i_term.multistep_sel ? i_multistep_freq : freq_r;
        else if (i_term.inching && i_term.remote)
            req_freq = i_inching_freq;
        else if (run_rise)
            req_freq = resume_r ? resume_freq_r : lower;
        else if (ramp_cnt_r == 32'd0 && i_term.remote)
        begin
            case (dir)
                DIR_UP:   req_freq = (freq_r >= upper) ? upper :
                                     16'(freq_r + updown_ref_pkg::RAMP_STEP);
                DIR_DOWN: req_freq = (freq_r <= lower) ? lower :
                                     16'(freq_r - updown_ref_pkg::RAMP_STEP);
                default:  req_freq = freq_r;
            endcase
        end
    end

    // The clamped request is the next reference value.
    assign freq_nxt = clamped;

    // Ramp pacing counter; multi-step selects never reach it.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            ramp_cnt_r <= 32'd0;
        else if (ramp_cnt_r == 32'd0)
            ramp_cnt_r <= 32'(updown_ref_pkg::RAMP_CYCLES - 1);
        else
            ramp_cnt_r <= ramp_cnt_r - 32'd1;
    end

    // Frequency register and run edge history.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            freq_r     <= 16'h0000;
            run_prev_r <= 1'b0;
        end
        else
        begin
            freq_r     <= init_req ? 16'h0000 : freq_nxt;
            run_prev_r <= run_cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hold timer and store.

    // Timer restarts on any single active input or a changed value.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            hold_cnt_r <= 40'd0;
            stored_r   <= 1'b0;
        end
        else if (dir != DIR_HOLD || freq_nxt != freq_r || !mode_updown)
        begin
            hold_cnt_r <= 40'd0;
            stored_r   <= 1'b0;
        end
        else if (hold_cnt_r < 40'(updown_ref_pkg::HOLD_CYCLES))
            hold_cnt_r <= hold_cnt_r + 40'd1;
        else if (o_store_wr)
            stored_r   <= 1'b1;
    end

    // One store per hold interval once five seconds have passed.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_store_wr   <= 1'b0;
            o_store_data <= 16'h0000;
        end
        else
        begin
            o_store_wr   <= (mem_sel_r == updown_ref_pkg::MEM_SEL_RETAIN) &&
                            mode_updown && dir == DIR_HOLD &&
                            freq_nxt == freq_r && !stored_r && !o_store_wr &&
                            hold_cnt_r >=
                            40'(updown_ref_pkg::HOLD_CYCLES);
            o_store_data <= freq_r;
        end
    end

    // Erase pulse on writing zero or an initialize request.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_store_erase <= 1'b0;
        else
            o_store_erase <= (mem_wr_hit &&
                              i_reg_wdata == updown_ref_pkg::MEM_SEL_OFF) ||
                             init_req;
    end

    // Registered outputs for the reference and mode.
    always_ff @(posedge i_sys_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_freq_ref      <= 16'h0000;
            o_updown_active <= 1'b0;
        end
        else
        begin
            o_freq_ref      <= freq_r;
            o_updown_active <= mode_updown;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence run_edge_s;
        mode_updown && !i_term.inching && run_rise && !resume_r && !init_req;
    endsequence

    run_lower_start_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        run_edge_s |=> (freq_r == $past(lower)))
        else $error("Run did not start at the lower limit.");

    upper_clamp_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        mode_updown && !init_req |=> freq_r <= $past(upper))
        else $error("Reference above upper limit.");

    hold_keeps_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        mode_updown && dir == DIR_HOLD && !run_rise && !i_term.inching &&
        !init_req && freq_r >= lower && freq_r <= upper
        |=> $stable(freq_r))
        else $error("Reference moved while held.");

    inching_wins_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        mode_updown && i_term.inching && i_term.remote && !init_req &&
        i_inching_freq >= lower && i_inching_freq <= upper
        |=> freq_r == $past(i_inching_freq))
        else $error("Inching did not override up/down.");

    store_needs_hold_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        o_store_wr |-> $past(hold_cnt_r) >=
                       40'(updown_ref_pkg::HOLD_CYCLES))
        else $error("Store before the hold time.");

    single_restart_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        mode_updown && dir != DIR_HOLD |=> hold_cnt_r == 40'd0)
        else $error("Hold timer not restarted.");

    erase_on_zero_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        mem_wr_hit && i_reg_wdata == updown_ref_pkg::MEM_SEL_OFF
        |=> o_store_erase ##1 !resume_r)
        else $error("Zero write did not erase.");

    init_clears_a: assert property (
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        init_req |=> freq_r == 16'h0000 && !resume_r)
        else $error("Initialize did not clear.");

endmodule

// *** term_switch_model.sv ***
// Switch model: the external contacts that drive the terminal inputs.
// Assumes the bench calls set; contacts change on the falling edge only.
`timescale 1ns/1ps

module term_switch_model
(
    input  wire logic                    i_sys_clk,
    output updown_ref_pkg::terminal_in_t o_term
);
    // All contacts open at power-up.
    initial
    begin
        o_term = '0;
    end

    // Moves the contacts at the next falling edge, clear of sampling.
    task automatic set(input updown_ref_pkg::terminal_in_t t);
        begin
            @(negedge i_sys_clk);
            o_term = t;
        end
    endtask
endmodule

// *** tb_updown_frequency_reference.sv ***
// Testbench for the up/down frequency reference block.
// Assumes the switch model drives the terminals; bench drives the rest.
`timescale 1ns/1ps

module tb_updown_frequency_reference;
    logic                            i_sys_clk;
    logic                            i_arst_n;
    updown_ref_pkg::terminal_in_t    term;
    updown_ref_pkg::limit_settings_t lim;
    logic [15:0]                     sel7;
    logic [15:0]                     init_sel;
    logic [15:0]                     inch_f;
    logic [15:0]                     ms_f;
    logic [15:0]                     ret_f;
    logic                            ret_v;
    logic                            wr;
    logic                            rd;
    logic [15:0]                     addr;
    logic [15:0]                     wdata;
    logic [15:0]                     rdata;
    logic [15:0]                     freq;
    logic                            upd;
    logic                            st_wr;
    logic [15:0]                     st_data;
    logic                            st_erase;
    logic [15:0]                     f0;
    int                              n_fail;
    int                              n_tests;
    int                              n_store;

    // Counts every store pulse the block issues.
    always @(posedge i_sys_clk)
    begin
        if (st_wr)
            n_store <= n_store + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock at 100 MHz and the units around the block.
    initial
    begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    term_switch_model sw_m
    (
        .i_sys_clk (i_sys_clk),
        .o_term    (term)
    );

    updown_frequency_reference dut
    (
        .i_sys_clk                 (i_sys_clk),
        .i_arst_n                  (i_arst_n),
        .i_term                    (term),
        .i_lim                     (lim),
        .i_input7_function_select  (sel7),
        .i_param_initialize_select (init_sel),
        .i_inching_freq            (inch_f),
        .i_multistep_freq          (ms_f),
        .i_retained_freq           (ret_f),
        .i_retained_valid          (ret_v),
        .i_reg_wr                  (wr),
        .i_reg_rd                  (rd),
        .i_reg_addr                (addr),
        .i_reg_wdata               (wdata),
        .o_reg_rdata               (rdata),
        .o_freq_ref                (freq),
        .o_updown_active           (upd),
        .o_store_wr                (st_wr),
        .o_store_data              (st_data),
        .o_store_erase             (st_erase)
    );

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks: compare, verdict, bus cycles, switches, bounded wait.
    task automatic check(input logic [15:0] seen, exp, input string m);
        begin
            n_tests++;
            if (seen !== exp)
            begin
                n_fail++;
                $display("unexpected at %0t: %s %h not %h", $time, m,
                         seen, exp);
            end
        end
    endtask

    task automatic give_verdict();
        begin
            $display("tests %0d, mismatches %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    task automatic reg_wr(input logic [15:0] a, d);
        begin
            @(negedge i_sys_clk);
            wr    = 1'b1;
            addr  = a;
            wdata = d;
            @(negedge i_sys_clk);
            wr    = 1'b0;
        end
    endtask

    task automatic reg_rd(input logic [15:0] a, exp);
        begin
            @(negedge i_sys_clk);
            rd   = 1'b1;
            addr = a;
            @(negedge i_sys_clk);
            rd   = 1'b0;
            check(rdata, exp, "read data");
        end
    endtask

    // Remote mode stays selected for every switch setting.
    task automatic sw(input logic up, dn, inch, fwd, rev, ms);
        begin
            sw_m.set('{up, dn, inch, fwd, rev, 1'b1, ms});
        end
    endtask

    // A wait that runs out counts a mismatch and ends the run.
    task automatic wait_freq(input logic [15:0] exp, input int n);
        int k;
        begin
            k = 0;
            while (freq !== exp && k < n)
            begin
                @(negedge i_sys_clk);
                k++;
            end
            check(freq, exp, "frequency");
            if (freq !== exp)
                give_verdict();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios; limits give upper 60 and lower 50.
    task automatic t_regs();
        begin
            check(freq, 16'h0000, "reset frequency");
            reg_rd(16'h0164, 16'h0000);
            reg_wr(16'h0165, 16'h0001);
            reg_rd(16'h0165, 16'h0000);
            reg_rd(16'h0164, 16'h0000);
            reg_wr(16'h0164, 16'h0001);
            reg_rd(16'h0164, 16'h0001);
            reg_wr(16'h0164, 16'h0000);
            check({15'h0000, st_erase}, 16'h0001, "erase");
            reg_rd(16'h0164, 16'h0000);
            $display("register test done");
        end
    endtask

    task automatic t_ramp();
        begin
            sel7 = updown_ref_pkg::INPUT7_UPDOWN_CODE;
            @(negedge i_sys_clk);
            @(negedge i_sys_clk);
            check({15'h0000, upd}, 16'h0001, "mode flag");
            sw(1, 0, 0, 1, 0, 0);
            wait_freq(16'h0032, 5);
            wait_freq(16'h0035, 3100);
            sw(1, 1, 0, 1, 0, 0);
            repeat (2500) @(negedge i_sys_clk);
            check(freq, 16'h0035, "hold both on");
            sw(0, 1, 0, 1, 0, 0);
            wait_freq(16'h0033, 2100);
            ms_f = 16'h003a;
            sw(0, 0, 0, 1, 0, 1);
            repeat (2500) @(negedge i_sys_clk);
            check(freq, 16'h0033, "multi-step ignored");
            $display("ramp test done");
        end
    endtask

    task automatic t_limits();
        logic [15:0] code [2];
        begin
            code = '{updown_ref_pkg::INIT_CODE_A,
                     updown_ref_pkg::INIT_CODE_B};
            sw(1, 0, 0, 1, 0, 0);
            wait_freq(16'h003c, 10000);
            repeat (2100) @(negedge i_sys_clk);
            check(freq, 16'h003c, "upper clamp");
            sw(0, 1, 0, 1, 0, 0);
            wait_freq(16'h0032, 11000);
            repeat (2100) @(negedge i_sys_clk);
            check(freq, 16'h0032, "lower clamp");
            foreach (code[i])
            begin
                sw(1, 0, 0, 1, 0, 0);
                wait_freq(16'h0034, 2100);
                sw(0, 0, 0, 1, 0, 0);
                init_sel = code[i];
                repeat (3) @(negedge i_sys_clk);
                check({15'h0000, st_erase}, 16'h0001, "init erase");
                init_sel = 16'h0000;
                wait_freq(16'h0032, 5);
            end
            $display("limit test done");
        end
    endtask

    task automatic t_inch_resume();
        begin
            inch_f = 16'h0037;
            sw(1, 0, 1, 1, 0, 0);
            wait_freq(16'h0037, 5);
            repeat (2100) @(negedge i_sys_clk);
            check(freq, 16'h0037, "inching priority");
            reg_wr(16'h0164, 16'h0001);
            ret_f = 16'h0039;
            ret_v = 1'b1;
            sw(0, 0, 0, 0, 0, 0);
            repeat (3) @(negedge i_sys_clk);
            ret_v = 1'b0;
            sw(0, 0, 0, 0, 1, 0);
            wait_freq(16'h0039, 5);
            reg_wr(16'h0164, 16'h0000);
            sw(0, 0, 0, 0, 0, 0);
            sw(0, 0, 0, 1, 0, 0);
            wait_freq(16'h0032, 5);
            check(16'(n_store), 16'h0000, "early store");
            sw_m.set('{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0});
            repeat (1100) @(negedge i_sys_clk);
            check(freq, 16'h0032, "local up ignored");
            sel7 = 16'h0000;
            repeat (2) @(negedge i_sys_clk);
            check({15'h0000, upd}, 16'h0000, "mode off");
            f0 = freq;
            sw(1, 0, 0, 0, 1, 0);
            repeat (2100) @(negedge i_sys_clk);
            check(freq, f0, "up ignored out of mode");
            $display("inching and resume test done");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: inputs at time zero, 8-cycle reset, then scenarios.
    initial
    begin
        n_fail   = 0;
        n_tests  = 0;
        i_arst_n = 1'b0;
        lim      = '{16'h03e8, 16'h003c, 16'h0032, 16'h0064};
        sel7     = 16'h0000;
        init_sel = 16'h0000;
        inch_f   = 16'h0000;
        ms_f     = 16'h0000;
        ret_f    = 16'h0000;
        ret_v    = 1'b0;
        wr       = 1'b0;
        rd       = 1'b0;
        addr     = 16'h0000;
        wdata    = 16'h0000;
        repeat (8) @(negedge i_sys_clk);
        i_arst_n = 1'b1;
        @(negedge i_sys_clk);
        t_regs();
        t_ramp();
        t_limits();
        t_inch_resume();
        give_verdict();
    end
endmodule
